// ===== core/ltp_host.sv
// host end: mirror generators, issues mode writes and training commands, checks reads
`timescale 1ns/1ns
module ltp_host
  import ltp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ltp_link_if.host link,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqMrs,
  input wire logic [1:0] reqAddr,
  input wire logic [`LTP_MR_W-1:0] reqData,
  input wire ltp_cmd_t reqCmd,
  output logic rdDone,
  output logic [`LTP_LANES-1:0] rdMismatch
);

  // ==========================================================
  // state
  typedef struct packed {
    ltp_gen_t gen;
    logic [1:0] busy;
    logic mrsValid;
    logic [1:0] mrsAddr;
    logic [`LTP_MR_W-1:0] mrsData;
    logic cmdValid;
    ltp_cmd_t cmdKind;
    ltp_burst_t hostDq;
    logic hostDqValid;
    ltp_burst_t expBurst;
    logic rdPend;
    logic rdDone;
    logic [`LTP_LANES-1:0] rdMismatch;
  } ltp_host_state_t;

  ltp_host_state_t state_reg;
  ltp_host_state_t state_next;
  ltp_burst_t pattern;
  logic take;
  logic train;

  assign pattern = ltpBurst(state_reg.gen);
  assign reqReady = (state_reg.busy == 2'h0);
  assign take = reqValid && reqReady;
  assign train = state_reg.gen.srcLfsr && (reqCmd == LTP_CMD_TRD || reqCmd == LTP_CMD_TWR);

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.mrsValid = 1'b0;
    state_next.cmdValid = 1'b0;
    state_next.hostDqValid = 1'b0;
    state_next.rdDone = 1'b0;
    if (state_reg.busy != 2'h0) begin
      state_next.busy = state_reg.busy - 2'h1;
    end
    if (link.devDqValid && state_reg.rdPend) begin
      state_next.rdPend = 1'b0;
      state_next.rdDone = 1'b1;
      for (int l = 0; l < `LTP_LANES; l++) begin
        state_next.rdMismatch[l] = (link.devDq[l] != state_reg.expBurst[l]);
      end
    end
    if (take && reqMrs) begin
      // user is expected to seed after reset and after a type change
      state_next.mrsValid = 1'b1;
      state_next.mrsAddr = reqAddr;
      state_next.mrsData = reqData;
      state_next.gen = ltpMrs(state_reg.gen, reqAddr, reqData);
    end else if (take) begin
      state_next.cmdValid = 1'b1;
      state_next.cmdKind = reqCmd;
      state_next.busy = `LTP_BURST_CLKS;
      if (train) begin
        state_next.gen = ltpAdvance(state_reg.gen);
        if (reqCmd == LTP_CMD_TWR) begin
          state_next.hostDq = pattern;
          state_next.hostDqValid = 1'b1;
        end else begin
          state_next.expBurst = pattern;
          state_next.rdPend = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.gen <= ltpInit();
      state_reg.cmdKind <= LTP_CMD_READ;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.mrsValid = state_reg.mrsValid;
  assign link.mrsAddr = state_reg.mrsAddr;
  assign link.mrsData = state_reg.mrsData;
  assign link.cmdValid = state_reg.cmdValid;
  assign link.cmdKind = state_reg.cmdKind;
  assign link.hostDq = state_reg.hostDq;
  assign link.hostDqValid = state_reg.hostDqValid;
  assign rdDone = state_reg.rdDone;
  assign rdMismatch = state_reg.rdMismatch;

endmodule

// ===== core/ltp_params.svh
// constants for the pseudo-random training pattern generator
`ifndef LTP_PARAMS_SVH
`define LTP_PARAMS_SVH
`define LTP_LANES 11
`define LTP_SYMS 16
`define LTP_STEP 24
`define LTP_LOOK 42
`define LTP_SEED_W 15
`define LTP_SEED11_W 11
`define LTP_GROUPS 3
`define LTP_TRIPLES 8
`define LTP_SHIFT_BITS 6
`define LTP_MR_W 12
`define LTP_BURST_CLKS 2'h2
// mode register offsets
`define LTP_MR_CFG 2'h0
`define LTP_MR_SEEDA 2'h1
`define LTP_MR_SEEDB 2'h2
`define LTP_MR_LANE 2'h3
// training_config_reg fields
`define LTP_CFG_SRC 0
`define LTP_CFG_TYPE 1
`define LTP_CFG_EYE 4
`define LTP_CFG_PAM3 6
// seed and lane_pattern_reg fields
`define LTP_SEED_GRP 8
`define LTP_LANE_IDX 4
`define LTP_SEED_RST 15'h0001
// symbol codes: two's complement trit
`define LTP_SYM_P 2'h1
`define LTP_SYM_Z 2'h0
`define LTP_SYM_N 2'h3
`define LTP_EYE_NONE 2'h0
`define LTP_EYE_LOWER 2'h1
`define LTP_EYE_UPPER 2'h2
`endif

// ===== core/ltp_pkg.sv
// types and shared pattern path of the training pattern generator
`include "ltp_params.svh"
package ltp_pkg;
  typedef enum logic [1:0] {LTP_CMD_READ, LTP_CMD_WRITE, LTP_CMD_TRD, LTP_CMD_TWR} ltp_cmd_t;
  typedef logic [`LTP_LANES-1:0][`LTP_SYMS-1:0][1:0] ltp_burst_t;
  typedef struct packed {
    logic [1:0] shift;
    logic inv;
    logic mask;
  } ltp_lane_t;
  typedef struct packed {
    logic srcLfsr;
    logic type11;
    logic [1:0] eyeCode;
    logic pam3;
    logic [`LTP_GROUPS-1:0][`LTP_SEED_W-1:0] seed;
    logic [`LTP_GROUPS-1:0][`LTP_SEED_W-1:0] lfsr;
    ltp_lane_t [`LTP_LANES-1:0] lane;
  } ltp_gen_t;

  // {S1,S0}
  function automatic logic [3:0] ltpEnc(input logic [2:0] t);
    logic [3:0] e;
    e = {`LTP_SYM_Z, `LTP_SYM_N};
    unique case (t)
      3'h0: e = {`LTP_SYM_Z, `LTP_SYM_N};
      3'h1: e = {`LTP_SYM_N, `LTP_SYM_P};
      3'h2: e = {`LTP_SYM_P, `LTP_SYM_N};
      3'h3: e = {`LTP_SYM_Z, `LTP_SYM_P};
      3'h4: e = {`LTP_SYM_N, `LTP_SYM_N};
      3'h5: e = {`LTP_SYM_N, `LTP_SYM_Z};
      3'h6: e = {`LTP_SYM_P, `LTP_SYM_Z};
      3'h7: e = {`LTP_SYM_P, `LTP_SYM_P};
    endcase
    return e;
  endfunction

  // 42-bit lookahead of a fibonacci register
  function automatic logic [`LTP_LOOK-1:0] ltpStream(input logic [`LTP_SEED_W-1:0] st, input logic type11);
    logic [`LTP_LOOK-1:0] b;
    b = {27'h0, st};
    if (type11) begin
      for (int n = `LTP_SEED11_W; n < `LTP_LOOK; n++) begin
        b[n] = b[n-11] ^ b[n-9];
      end
    end else begin
      for (int n = `LTP_SEED_W; n < `LTP_LOOK; n++) begin
        b[n] = b[n-15] ^ b[n-14];
      end
    end
    return b;
  endfunction

  function automatic logic [`LTP_SEED_W-1:0] ltpLoad(input logic [`LTP_SEED_W-1:0] s, input logic type11);
    return type11 ? {4'h0, s[`LTP_SEED11_W-1:0]} : s;
  endfunction

  // inversion, then lane mask, then eye mask
  function automatic logic [1:0] ltpPost(input logic [1:0] sym, input ltp_lane_t ln, input logic [1:0] eye);
    logic [1:0] s;
    s = ln.inv ? 2'h0 - sym : sym;
    if (ln.mask) begin
      s = (eye == `LTP_EYE_UPPER) ? `LTP_SYM_Z : `LTP_SYM_P;
    end else if (eye == `LTP_EYE_LOWER && s == `LTP_SYM_N) begin
      s = `LTP_SYM_Z;
    end else if (eye == `LTP_EYE_UPPER && s == `LTP_SYM_P) begin
      s = `LTP_SYM_Z;
    end
    return s;
  endfunction

  function automatic ltp_burst_t ltpBurst(input ltp_gen_t g);
    ltp_burst_t o;
    logic [`LTP_LOOK-1:0] b;
    logic [3:0] e;
    logic [1:0] eye;
    int grp;
    int off;
    o = '0;
    // eye masking exists only in pam3 signalling
    eye = g.pam3 ? g.eyeCode : `LTP_EYE_NONE;
    for (int l = 0; l < `LTP_LANES; l++) begin
      grp = (l < 4) ? 0 : (l < 8) ? 1 : 2;
      b = ltpStream(g.lfsr[grp], g.type11);
      off = `LTP_SHIFT_BITS * int'(g.lane[l].shift);
      for (int k = 0; k < `LTP_TRIPLES; k++) begin
        e = ltpEnc(b[off + 3*k +: 3]);
        o[l][2*k] = ltpPost(e[3:2], g.lane[l], eye);
        o[l][2*k+1] = ltpPost(e[1:0], g.lane[l], eye);
      end
    end
    return o;
  endfunction

  function automatic ltp_gen_t ltpAdvance(input ltp_gen_t g);
    ltp_gen_t o;
    logic [`LTP_LOOK-1:0] b;
    o = g;
    for (int i = 0; i < `LTP_GROUPS; i++) begin
      b = ltpStream(g.lfsr[i], g.type11);
      o.lfsr[i] = b[`LTP_STEP +: `LTP_SEED_W];
    end
    return o;
  endfunction

  function automatic ltp_gen_t ltpInit();
    ltp_gen_t o;
    o = '0;
    for (int i = 0; i < `LTP_GROUPS; i++) begin
      o.seed[i] = `LTP_SEED_RST;
      o.lfsr[i] = `LTP_SEED_RST;
    end
    return o;
  endfunction

  // mode register write, same decode at both ends
  function automatic ltp_gen_t ltpMrs(input ltp_gen_t g, input logic [1:0] a, input logic [`LTP_MR_W-1:0] d);
    ltp_gen_t o;
    logic [1:0] grp;
    logic [3:0] idx;
    o = g;
    grp = d[`LTP_SEED_GRP +: 2];
    idx = d[`LTP_LANE_IDX +: 4];
    unique case (a)
      `LTP_MR_CFG: begin
        o.srcLfsr = d[`LTP_CFG_SRC];
        o.type11 = d[`LTP_CFG_TYPE];
        o.eyeCode = d[`LTP_CFG_EYE +: 2];
        o.pam3 = d[`LTP_CFG_PAM3];
      end
      `LTP_MR_SEEDA: begin
        if (grp < 2'h3) begin
          o.seed[grp][7:0] = d[7:0];
          o.lfsr[grp] = ltpLoad(o.seed[grp], o.type11);
        end
      end
      `LTP_MR_SEEDB: begin
        if (grp < 2'h3) begin
          o.seed[grp][14:8] = d[6:0];
          o.lfsr[grp] = ltpLoad(o.seed[grp], o.type11);
        end
      end
      `LTP_MR_LANE: begin
        if (idx < 4'hb) begin
          // field by field: the struct packs shift on top, the register keeps it in the low bits
          o.lane[idx].shift = d[1:0];
          o.lane[idx].inv = d[2];
          o.lane[idx].mask = d[3];
        end
      end
    endcase
    return o;
  endfunction
endpackage

// ===== core/ltp_link_if.sv
// link between memory controller and device pattern generators
`timescale 1ns/1ns
interface ltp_link_if;
  import ltp_pkg::*;
  logic mrsValid;
  logic [1:0] mrsAddr;
  logic [`LTP_MR_W-1:0] mrsData;
  logic cmdValid;
  ltp_cmd_t cmdKind;
  ltp_burst_t hostDq;
  logic hostDqValid;
  ltp_burst_t devDq;
  logic devDqValid;
  modport dev(input mrsValid, mrsAddr, mrsData, cmdValid, cmdKind, hostDq, hostDqValid,
              output devDq, devDqValid);
  modport host(output mrsValid, mrsAddr, mrsData, cmdValid, cmdKind, hostDq, hostDqValid,
               input devDq, devDqValid);
endinterface

// ===== core/ltp_device.sv
// device end: seeded generators, pattern path, training read drive and write compare
//
// Contract
// - 3 bits map to two pam3 symbols
// - lowest triple bit is encoder lsb
// - stream advances 24 bits per burst
// - 42-bit window, lookahead allows 12-symbol shift
// - three generators, own 15-bit seeds
// - 15-bit type loads full seed
// - 11-bit type loads seed bits 10:0
// - fibonacci polynomials, type shared by all
// - feedback continues sequence each burst
// - host seeds all generators before training
// - training commands advance every generator when source select is set
// - ordinary read/write leave generators unchanged
// - host reseeds after init, reset, type change
// - order is invert, lane mask, eye mask
// - inversion swaps +1 and -1
// - lane mask forces +1 or 0
// - eye mask zeroes one polarity
// - host and device paths identical
// - host sequence: setup, seed, reads, writes
// - lanes 3:0, 7:4, 9:8 plus extra
// - pattern source only when select set
// - one eye mask, pam3 only
`timescale 1ns/1ns
module ltp_device
  import ltp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ltp_link_if.dev link,
  output logic patternActive,
  output logic fifoCmd,
  output logic wrDone,
  output logic [`LTP_LANES-1:0] wrMismatch,
  output logic [`LTP_GROUPS-1:0][`LTP_SEED_W-1:0] genState
);

  // ==========================================================
  // state
  typedef enum logic {LTP_DEV_IDLE, LTP_DEV_HOLD} ltp_dev_phase_t;

  typedef struct packed {
    ltp_dev_phase_t phase;
    ltp_gen_t gen;
    ltp_burst_t devDq;
    logic devDqValid;
    logic fifoCmd;
    logic wrDone;
    logic [`LTP_LANES-1:0] wrMismatch;
  } ltp_dev_state_t;

  ltp_dev_state_t state_reg;
  ltp_dev_state_t state_next;
  ltp_burst_t pattern;
  logic trainCmd;

  // ==========================================================
  // pattern of the current step
  // encoder, shift, inversion and masks live in the package so both ends share them
  assign pattern = ltpBurst(state_reg.gen);

  assign trainCmd = link.cmdValid && (link.cmdKind == LTP_CMD_TRD || link.cmdKind == LTP_CMD_TWR);

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.fifoCmd = 1'b0;
    state_next.wrDone = 1'b0;
    unique case (state_reg.phase)
      LTP_DEV_IDLE: begin
        state_next.devDqValid = 1'b0;
        if (trainCmd && !state_reg.gen.srcLfsr) begin
          // fifo training is handled outside; just flag it
          state_next.fifoCmd = 1'b1;
        end else if (trainCmd) begin
          state_next.gen = ltpAdvance(state_reg.gen);
          state_next.phase = LTP_DEV_HOLD;
          if (link.cmdKind == LTP_CMD_TRD) begin
            state_next.devDq = pattern;
            state_next.devDqValid = 1'b1;
          end else begin
            state_next.wrDone = 1'b1;
            for (int l = 0; l < `LTP_LANES; l++) begin
              state_next.wrMismatch[l] = !link.hostDqValid || (link.hostDq[l] != pattern[l]);
            end
          end
        end
        // plain read and write fall through untouched
      end
      LTP_DEV_HOLD: begin
        // burst spans two clocks; commands here are ignored
        state_next.phase = LTP_DEV_IDLE;
      end
    endcase
    if (link.mrsValid) begin
      // applied after any advance, so a seed write always wins
      state_next.gen = ltpMrs(state_next.gen, link.mrsAddr, link.mrsData);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg.phase <= LTP_DEV_IDLE;
      state_reg.gen <= ltpInit();
      state_reg.devDq <= '0;
      state_reg.devDqValid <= 1'b0;
      state_reg.fifoCmd <= 1'b0;
      state_reg.wrDone <= 1'b0;
      state_reg.wrMismatch <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign link.devDq = state_reg.devDq;
  assign link.devDqValid = state_reg.devDqValid;
  assign patternActive = state_reg.gen.srcLfsr;
  assign fifoCmd = state_reg.fifoCmd;
  assign wrDone = state_reg.wrDone;
  assign wrMismatch = state_reg.wrMismatch;
  assign genState = state_reg.gen.lfsr;

endmodule

// ===== test/ltp_link_assertions.sv
// concurrent checks on the link between the two pattern generators
`timescale 1ns/1ns
`include "ltp_params.svh"
module ltp_link_assertions
  import ltp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mrsValid,
  input wire logic [1:0] mrsAddr,
  input wire logic [`LTP_MR_W-1:0] mrsData,
  input wire logic cmdValid,
  input wire ltp_cmd_t cmdKind,
  input wire ltp_burst_t hostDq,
  input wire logic hostDqValid,
  input wire ltp_burst_t devDq,
  input wire logic devDqValid
);
  // ==========================================================
  // helper state
  logic trdD;
  logic srcOn;
  logic badSym;

  // source select mirrored from mode writes, fifo mode gives no burst
  always_ff @(posedge clk) begin
    if (rst) begin
      trdD <= 1'b0;
      srcOn <= 1'b0;
    end else begin
      trdD <= cmdValid && cmdKind == LTP_CMD_TRD;
      if (mrsValid && mrsAddr == `LTP_MR_CFG) begin
        srcOn <= mrsData[`LTP_CFG_SRC];
      end
    end
  end

  always_comb begin
    badSym = 1'b0;
    for (int l = 0; l < `LTP_LANES; l++) begin
      for (int s = 0; s < `LTP_SYMS; s++) begin
        badSym = badSym | (devDq[l][s] == 2'h2);
      end
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence dqBurst;
    devDqValid [*2] ##1 !devDqValid;
  endsequence
  sequence trdCmd;
    cmdValid && cmdKind == LTP_CMD_TRD && srcOn;
  endsequence

  chk_dq_burst_len: assert property ($rose(devDqValid) |-> dqBurst)
    else $error("read burst valid not two cycles");
  chk_dq_held: assert property (devDqValid && !$rose(devDqValid) |-> $stable(devDq))
    else $error("read burst changed while valid");
  chk_trd_answer: assert property (trdCmd |=> $rose(devDqValid))
    else $error("training read got no burst");
  chk_dq_cause: assert property ($rose(devDqValid) |-> trdD)
    else $error("burst without training read");
  chk_cmd_spacing: assert property (cmdValid |=> (!cmdValid) [*2])
    else $error("commands closer than a burst cycle");
  chk_twr_data: assert property (cmdValid && cmdKind == LTP_CMD_TWR && srcOn |-> hostDqValid)
    else $error("training write without data");
  chk_data_twr: assert property (hostDqValid |-> cmdValid && cmdKind == LTP_CMD_TWR)
    else $error("write data without training write");
  chk_sym_legal: assert property (devDqValid |-> !badSym)
    else $error("invalid symbol code on read burst");
  chk_reset_quiet: assert property ($fell(rst) |-> !(mrsValid || cmdValid || devDqValid))
    else $error("link active right after reset");
endmodule

// ===== test/tb.sv
// self-checking bench for the paired training pattern generators
`timescale 1ns/1ns
`include "ltp_params.svh"
module tb
  import ltp_pkg::*;
;
  // ==========================================================
  // signals and instances
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqMrs = 1'b0;
  logic [1:0] reqAddr = 2'h0;
  logic [11:0] reqData = 12'h0;
  ltp_cmd_t reqCmd = LTP_CMD_READ;
  logic reqReady, rdDone, patternActive, fifoCmd, wrDone;
  logic [10:0] rdMismatch, wrMismatch;
  logic [2:0][14:0] genState;
  int n_errors = 0;
  int samples_checked = 0;
  logic [14:0] st [3];
  logic [3:0] lc [11];
  logic t11, src;
  logic [1:0] eye;
  // {S1,S0} for inputs 7..0
  localparam logic [31:0] encTab = 32'h54cf17d3;

  always #50 clk = ~clk;

  ltp_link_if lnk ();
  ltp_device ltp_device_i (.clk(clk), .rst(rst), .link(lnk.dev), .patternActive(patternActive),
    .fifoCmd(fifoCmd), .wrDone(wrDone), .wrMismatch(wrMismatch), .genState(genState));
  ltp_host ltp_host_i (.clk(clk), .rst(rst), .link(lnk.host), .reqValid(reqValid), .reqReady(reqReady),
    .reqMrs(reqMrs), .reqAddr(reqAddr), .reqData(reqData), .reqCmd(reqCmd), .rdDone(rdDone),
    .rdMismatch(rdMismatch));
  ltp_link_assertions ltp_link_assertions_i (.clk(clk), .rst(rst), .mrsValid(lnk.mrsValid),
    .mrsAddr(lnk.mrsAddr), .mrsData(lnk.mrsData), .cmdValid(lnk.cmdValid), .cmdKind(lnk.cmdKind),
    .hostDq(lnk.hostDq), .hostDqValid(lnk.hostDqValid), .devDq(lnk.devDq), .devDqValid(lnk.devDqValid));

  // ==========================================================
  // reference model
  function automatic logic [41:0] strm(input logic [14:0] s, input logic typ);
    logic [41:0] b;
    b = {27'h0, s};
    for (int n = 11; n < 42; n++) begin
      if (typ) b[n] = b[n-11] ^ b[n-9];
      else if (n > 14) b[n] = b[n-15] ^ b[n-14];
    end
    return b;
  endfunction

  function automatic logic [31:0] expLane(input int l);
    logic [41:0] b;
    logic [3:0] e;
    logic [1:0] s;
    logic [31:0] o;
    b = strm(st[l < 4 ? 0 : l < 8 ? 1 : 2], t11);
    for (int k = 0; k < 16; k++) begin
      e = encTab[4 * b[6 * lc[l][1:0] + 3 * (k / 2) +: 3] +: 4];
      s = k[0] ? e[1:0] : e[3:2];
      if (lc[l][2]) s = (s == 2'h1) ? 2'h3 : (s == 2'h3) ? 2'h1 : s;
      if (lc[l][3]) s = (eye == 2'h2) ? 2'h0 : 2'h1;
      else if ((eye == 2'h1 && s == 2'h3) || (eye == 2'h2 && s == 2'h1)) s = 2'h0;
      o[2*k +: 2] = s;
    end
    return o;
  endfunction

  // ==========================================================
  // tasks
  task automatic final_report();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded poll: 0 burst, 1 write compared, 2 fifo command, 3 ready
  task automatic waitSig(input int w);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if ((w == 0 && lnk.devDqValid === 1'b1) || (w == 1 && wrDone === 1'b1) ||
          (w == 2 && fifoCmd === 1'b1) || (w == 3 && reqReady === 1'b1)) return;
    end
    n_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report();
  endtask

  task automatic req(input logic m, input logic [1:0] a, input logic [11:0] d, input ltp_cmd_t c);
    waitSig(3);
    @(posedge clk);
    reqValid <= 1'b1;
    reqMrs <= m;
    reqAddr <= a;
    reqData <= d;
    reqCmd <= c;
    @(posedge clk);
    reqValid <= 1'b0;
  endtask

  task automatic runCmd(input ltp_cmd_t c);
    logic [41:0] b;
    req(1'b0, 2'h0, 12'h0, c);
    if (c == LTP_CMD_TRD) begin
      waitSig(0);
      for (int l = 0; l < 11; l++) chk(lnk.devDq[l], expLane(l));
      @(posedge clk);
      #1;
      chk({rdDone, rdMismatch}, {1'b1, 11'h0});
    end else if (c == LTP_CMD_TWR) begin
      waitSig(1);
      chk(wrMismatch, 11'h0);
    end else begin
      repeat (3) @(posedge clk);
      #1;
    end
    for (int g = 0; g < 3; g++) begin
      b = strm(st[g], t11);
      if (c[1] && src) st[g] = b[38:24];
    end
    chk(genState, {st[2], st[1], st[0]});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [14:0] s;
    logic pam;
    logic [1:0] eyeRaw;
    void'($urandom(48));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(genState, {3{15'h0001}});
    for (int p = 0; p < 4; p++) begin
      t11 = p[0];
      src = 1'b1;
      pam = p != 3;
      eyeRaw = 2'($urandom_range(2));
      eye = pam ? eyeRaw : 2'h0;
      req(1'b1, 2'h0, {5'h0, pam, eyeRaw, 2'h0, t11, src}, LTP_CMD_READ);
      for (int g = 0; g < 3; g++) begin
        s = 15'($urandom);
        req(1'b1, 2'h1, {2'h0, 2'(g), s[7:0]}, LTP_CMD_READ);
        req(1'b1, 2'h2, {2'h0, 2'(g), 1'b0, s[14:8]}, LTP_CMD_READ);
        st[g] = t11 ? {4'h0, s[10:0]} : s;
      end
      // group 3 and lane 15 do not exist, both writes must be dropped
      req(1'b1, 2'h1, 12'h3ff, LTP_CMD_READ);
      for (int l = 0; l < 11; l++) begin
        lc[l] = p == 0 ? 4'h0 : 4'($urandom);
        req(1'b1, 2'h3, {4'h0, 4'(l), lc[l]}, LTP_CMD_READ);
      end
      req(1'b1, 2'h3, 12'h0ff, LTP_CMD_READ);
      @(posedge clk);
      #1;
      chk(genState, {st[2], st[1], st[0]});
      chk(patternActive, 1'b1);
      for (int r = 0; r < 8; r++) runCmd(ltp_cmd_t'(r < 4 ? r : $urandom_range(3)));
      $display("test %0d done", p);
    end
    src = 1'b0;
    req(1'b1, 2'h0, 12'h0, LTP_CMD_READ);
    req(1'b0, 2'h0, 12'h0, LTP_CMD_TWR);
    waitSig(2);
    chk(patternActive, 1'b0);
    chk(genState, {st[2], st[1], st[0]});
    $display("test fifo done");
    final_report();
  end
endmodule
